// ==== common/sgl_regs.svh ====
`ifndef SGL_REGS_SVH
`define SGL_REGS_SVH

// Gain word width and special codes
`define SGL_WORD_W 8
`define SGL_MSB_POS 7
`define SGL_CODE_ISOLATE 8'h00
`define SGL_CODE_MAX 8'h80
`define SGL_BIT_CNT_W 4
`define SGL_BITS_PER_WORD 4'h8

// Power-down input filter: 2 sync stages only, no debounce
`define SGL_SYNC_W 2

`endif

// ==== common/sgl_pkg.sv ====
package sgl_pkg;
    typedef logic [7:0] sgl_word_t;
    typedef enum logic [1:0] {
        SGL_GAIN_ISOLATE,
        SGL_GAIN_SCALED,
        SGL_GAIN_MAX
    } sgl_gain_mode_e;
endpackage

// ==== common/sgl_edge_if.sv ====
interface sgl_edge_if;
    logic data;
    logic window_n;
    logic clk_rise;
    logic clk_fall;
    logic win_fall;
    logic win_rise;
    logic power_n;
    modport producer(output data, output window_n, output clk_rise, output clk_fall,
        output win_fall, output win_rise, output power_n);
    modport consumer(input data, input window_n, input clk_rise, input clk_fall,
        input win_fall, input win_rise, input power_n);
endinterface

// ==== rtl/sgl_pin_sync.sv ====
`include "sgl_regs.svh"

module sgl_pin_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic shift_clk_i,
    input wire logic serial_gain_in_i,
    input wire logic load_window_n_i,
    input wire logic power_down_n_i,
    sgl_edge_if.producer edge_o
);
    // Stage 0 feeds stage 1 only; edges are taken between stage 1 and stage 2
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [1:0] prev_ff;
    logic [3:0] nxt_meta;
    logic [3:0] nxt_sync;
    logic [1:0] nxt_prev;

    always_comb begin
        nxt_meta = {power_down_n_i, load_window_n_i, serial_gain_in_i, shift_clk_i};
        nxt_sync = meta_ff;
        nxt_prev = {sync_ff[2], sync_ff[0]};
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_ff <= 4'h6;
            sync_ff <= 4'h6;
            prev_ff <= 2'h2;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    assign edge_o.data = sync_ff[1];
    assign edge_o.window_n = sync_ff[2];
    assign edge_o.power_n = sync_ff[3];
    assign edge_o.clk_rise = sync_ff[0] & ~prev_ff[0];
    assign edge_o.clk_fall = ~sync_ff[0] & prev_ff[0];
    assign edge_o.win_fall = ~sync_ff[2] & prev_ff[1];
    assign edge_o.win_rise = sync_ff[2] & ~prev_ff[1];
endmodule

// ==== rtl/sgl_gain_loader.sv ====
`include "sgl_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module sgl_gain_loader (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic shift_clk_i,
    input wire logic serial_gain_in_i,
    input wire logic load_window_n_i,
    input wire logic power_down_n_i,
    output logic [7:0] gain_code_o,
    output logic [2:0] gain_step_o,
    output logic [6:0] gain_fine_o,
    output sgl_pkg::sgl_gain_mode_e gain_mode_o,
    output logic forward_en_o,
    output logic isolate_o,
    output logic [3:0] bits_seen_o,
    output logic shifting_o
);
    sgl_edge_if pins ();

    sgl_pin_sync u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .shift_clk_i(shift_clk_i),
        .serial_gain_in_i(serial_gain_in_i),
        .load_window_n_i(load_window_n_i),
        .power_down_n_i(power_down_n_i),
        .edge_o(pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shift path
    typedef enum logic [1:0] {SGL_IDLE, SGL_ARMED} sgl_state_e;

    sgl_state_e state_ff;
    sgl_state_e nxt_state;
    logic master_ff;
    logic nxt_master;
    logic [7:0] slave_ff;
    logic [7:0] nxt_slave;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    always_comb begin
        nxt_state = state_ff;
        nxt_master = master_ff;
        nxt_slave = slave_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            SGL_IDLE: begin
                // Clock edges here are ignored
                if (pins.win_fall) begin
                    nxt_state = SGL_ARMED;
                    nxt_cnt = 4'h0;
                end
            end
            SGL_ARMED: begin
                if (pins.win_rise) begin
                    nxt_state = SGL_IDLE;
                end else begin
                    if (pins.clk_rise) begin
                        nxt_master = pins.data;
                    end
                    if (pins.clk_fall) begin
                        // Older bits fall off the top, so extra edges keep the last eight
                        nxt_slave = {slave_ff[6:0], master_ff};
                        if (cnt_ff != 4'hf) begin
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                end
            end
            default: begin
                nxt_state = SGL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= SGL_IDLE;
            master_ff <= 1'b0;
            slave_ff <= 8'h00;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            master_ff <= nxt_master;
            slave_ff <= nxt_slave;
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain latch and decode
    // A final rising clock left without its falling edge would be lost at the
    // window rise; the master bit is folded in so that word still lands.
    logic pend_ff;
    logic nxt_pend;
    logic [7:0] word;
    logic [7:0] nxt_code;
    logic [2:0] nxt_step;
    logic [6:0] nxt_fine;
    sgl_pkg::sgl_gain_mode_e nxt_mode;
    logic [7:0] code_ff;
    logic [2:0] step_ff;
    logic [6:0] fine_ff;
    sgl_pkg::sgl_gain_mode_e mode_ff;
    logic fwd_ff;
    logic iso_ff;
    logic [3:0] seen_ff;
    logic shifting_ff;

    always_comb begin
        nxt_pend = pend_ff;
        if (state_ff != SGL_ARMED || pins.win_rise) begin
            nxt_pend = 1'b0;
        end else if (pins.clk_rise) begin
            nxt_pend = 1'b1;
        end else if (pins.clk_fall) begin
            nxt_pend = 1'b0;
        end
        word = pend_ff ? {slave_ff[6:0], master_ff} : slave_ff;
        // Held code changes only at the window rise
        nxt_code = code_ff;
        if (state_ff == SGL_ARMED && pins.win_rise) begin
            nxt_code = word;
        end
        // Step is the position of the top set bit, one per doubling
        nxt_step = 3'h0;
        nxt_fine = 7'h00;
        for (int i = 0; i < `SGL_WORD_W - 1; i++) begin
            if (code_ff[i]) begin
                nxt_step = 3'(i);
            end
        end
        if (code_ff == `SGL_CODE_ISOLATE) begin
            nxt_mode = sgl_pkg::SGL_GAIN_ISOLATE;
        end else if (code_ff[`SGL_MSB_POS]) begin
            nxt_mode = sgl_pkg::SGL_GAIN_MAX;
            nxt_step = 3'h7;
        end else begin
            nxt_mode = sgl_pkg::SGL_GAIN_SCALED;
            nxt_fine = code_ff[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_ff <= 1'b0;
            code_ff <= `SGL_CODE_ISOLATE;
            step_ff <= 3'h0;
            fine_ff <= 7'h00;
            mode_ff <= sgl_pkg::SGL_GAIN_ISOLATE;
            fwd_ff <= 1'b0;
            iso_ff <= 1'b1;
            seen_ff <= 4'h0;
            shifting_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            code_ff <= nxt_code;
            step_ff <= nxt_step;
            fine_ff <= nxt_fine;
            mode_ff <= nxt_mode;
            // Power-down gates only the output; codes are untouched
            fwd_ff <= pins.power_n;
            iso_ff <= (nxt_mode == sgl_pkg::SGL_GAIN_ISOLATE);
            seen_ff <= cnt_ff;
            shifting_ff <= (state_ff == SGL_ARMED);
        end
    end

    assign gain_code_o = code_ff;
    assign gain_step_o = step_ff;
    assign gain_fine_o = fine_ff;
    assign gain_mode_o = mode_ff;
    assign forward_en_o = fwd_ff;
    assign isolate_o = iso_ff;
    assign bits_seen_o = seen_ff;
    assign shifting_o = shifting_ff;
endmodule

// ==== verification/sgl_gain_loader_chk.sv ====
module sgl_gain_loader_chk (
    input logic clk_i,
    input logic reset_i,
    input logic load_window_n_i,
    input logic power_down_n_i,
    input logic [7:0] gain_code_o,
    input logic [2:0] gain_step_o,
    input logic [6:0] gain_fine_o,
    input sgl_pkg::sgl_gain_mode_e gain_mode_o,
    input logic forward_en_o,
    input logic isolate_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Two sync stages plus the forward register flush their reset values over three edges after release
    a_fwd_follows_pd: assert property (
        !$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3)
        |-> forward_en_o == $past(power_down_n_i, 3)) else $error("forward lag");
    a_isolate_mode: assert property (
        isolate_o == (gain_mode_o == sgl_pkg::SGL_GAIN_ISOLATE)) else $error("isolate");
    a_zero_isolates: assert property (
        $past(gain_code_o) == 8'h00 |-> isolate_o) else $error("zero code");
    a_msb_max: assert property (
        $past(gain_code_o[7]) |-> gain_mode_o == sgl_pkg::SGL_GAIN_MAX
        && gain_step_o == 3'h7) else $error("msb max");
    a_mid_scaled: assert property (
        $past(gain_code_o) inside {[8'h01:8'h7f]} |-> gain_mode_o == sgl_pkg::SGL_GAIN_SCALED
        && gain_fine_o == $past(gain_code_o[6:0])) else $error("scaled");
    a_step_doubles: assert property (
        gain_mode_o == sgl_pkg::SGL_GAIN_SCALED |-> (gain_fine_o >> gain_step_o) == 7'h01)
        else $error("step");
    a_hold_shift: assert property (
        !load_window_n_i [*5] |-> $stable(gain_code_o)) else $error("hold");
    a_code_on_rise: assert property (
        $changed(gain_code_o) |-> $past(load_window_n_i, 2) && $past(load_window_n_i, 3))
        else $error("latch");
    c_load: cover property ($rose(load_window_n_i));
    c_max: cover property (gain_mode_o == sgl_pkg::SGL_GAIN_MAX);
    c_pd: cover property ($fell(forward_en_o));
endmodule

bind sgl_gain_loader sgl_gain_loader_chk i_chk (.clk_i, .reset_i, .load_window_n_i,
    .power_down_n_i, .gain_code_o, .gain_step_o, .gain_fine_o, .gain_mode_o,
    .forward_en_o, .isolate_o);

// ==== verification/sgl_host_model.sv ====
module sgl_host_model (
    input wire logic clk_i,
    output logic shift_clk_o,
    output logic serial_gain_in_o,
    output logic load_window_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shift_clk_o = 1'b0;
        serial_gain_in_o = 1'b0;
        load_window_n_o = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic open_win();
        hold(1);
        load_window_n_o = 1'b0;
        hold(4);
    endtask
    // Data leads the rise by half a period; clock rests low between frames
    task automatic send_bit(input logic b);
        serial_gain_in_o = b;
        hold(4);
        shift_clk_o = 1'b1;
        hold(4);
        shift_clk_o = 1'b0;
    endtask
    // Released data flips so a stale bit cannot pass for a real one
    task automatic close_win();
        hold(4);
        load_window_n_o = 1'b1;
        serial_gain_in_o = ~serial_gain_in_o;
    endtask
endmodule

// ==== verification/testbench.sv ====
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic power_down_n_i = 1'b0;
    logic sclk, sdat, swin, forward_en_o, isolate_o, shifting_o;
    logic [3:0] bits_seen_o;
    logic [7:0] gain_code_o;
    logic [2:0] gain_step_o;
    logic [6:0] gain_fine_o;
    sgl_pkg::sgl_gain_mode_e gain_mode_o;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h000110a3;
    logic [7:0] cur = 8'h00;
    logic [7:0] corner [6] = '{8'h00, 8'h80, 8'hff, 8'h01, 8'h40, 8'h7f};
    always #12.5 clk_i = ~clk_i;
    sgl_host_model i_sgl_host_model (.clk_i, .shift_clk_o(sclk), .serial_gain_in_o(sdat),
        .load_window_n_o(swin));
    sgl_gain_loader i_sgl_gain_loader (.clk_i, .reset_i, .shift_clk_i(sclk),
        .serial_gain_in_i(sdat), .load_window_n_i(swin), .power_down_n_i, .gain_code_o,
        .gain_step_o, .gain_fine_o, .gain_mode_o, .forward_en_o, .isolate_o,
        .bits_seen_o, .shifting_o);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [2:0] top_bit(input logic [7:0] c);
        top_bit = 3'h0;
        for (int i = 0; i < 8; i++)
            if (c[i])
                top_bit = i[2:0];
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic load(input logic [7:0] w, input int extra);
        sgl_pkg::sgl_gain_mode_e m;
        m = (w == 8'h00) ? sgl_pkg::SGL_GAIN_ISOLATE :
            (w[7] ? sgl_pkg::SGL_GAIN_MAX : sgl_pkg::SGL_GAIN_SCALED);
        i_sgl_host_model.open_win();
        for (int i = 0; i < extra; i++) begin
            seed = lfsr(seed);
            i_sgl_host_model.send_bit(seed[0]);
        end
        for (int i = 7; i >= 0; i--) begin
            i_sgl_host_model.send_bit(w[i]);
            if (i == 4) begin
                `CHK("code_hold", cur, gain_code_o)
                `CHK("shifting", 1'b1, shifting_o)
            end
        end
        i_sgl_host_model.close_win();
        cur = w;
        i_sgl_host_model.hold(6);
        `CHK("gain_code", w, gain_code_o)
        `CHK("gain_mode", m, gain_mode_o)
        `CHK("gain_step", top_bit(w), gain_step_o)
        `CHK("gain_fine", (m == sgl_pkg::SGL_GAIN_SCALED) ? w[6:0] : 7'h00, gain_fine_o)
        `CHK("isolate", w == 8'h00, isolate_o)
        `CHK("shift_done", 1'b0, shifting_o)
        // Falling edges saturate at fifteen
        `CHK("bits_seen", (extra > 7) ? 4'hf : 4'(8 + extra), bits_seen_o)
        $display("test load %h extra %0d done", w, extra);
    endtask
    initial begin
        i_sgl_host_model.hold(5);
        reset_i = 1'b0;
        // Power-down is still held low through the first load, so forward stays off
        load(8'h5a, 0);
        `CHK("fwd_off", 1'b0, forward_en_o)
        power_down_n_i = 1'b1;
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            load(k < 6 ? corner[k] : seed[15:8], k < 6 ? 0 : int'(seed[2:0]));
        end
        for (int i = 0; i < 8; i++)
            i_sgl_host_model.send_bit(~cur[i]);
        // An empty window latches the shift register as is, exposing any stray shifts
        i_sgl_host_model.open_win();
        i_sgl_host_model.close_win();
        i_sgl_host_model.hold(6);
        `CHK("closed_win", cur, gain_code_o)
        `CHK("empty_win", 4'h0, bits_seen_o)
        power_down_n_i = 1'b0;
        i_sgl_host_model.hold(4);
        `CHK("fwd_off", 1'b0, forward_en_o)
        `CHK("pd_code", cur, gain_code_o)
        power_down_n_i = 1'b1;
        i_sgl_host_model.hold(4);
        `CHK("fwd_on", 1'b1, forward_en_o)
        $display("test power done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
